/* logic/pdv_pkg.sv */
// constants for the peripheral decode and interrupt vector block
// assumes one system clock; peripherals and core sit on the same clock
// How it works
// RULE1 - each vector belongs to one peripheral; that peripheral may feed it from several sources
// RULE2 - a peripheral's interrupt condition sets its matching flag bit
// RULE3 - each source has its own enable bit written by software
// RULE4 - a request exists only while both flag and enable are set
// RULE5 - a request holds, level style, until its flag is cleared
// RULE6 - maskable requests also need the global interrupt enable
// RULE7 - reset vector at word 0x00, memory check nonmaskable vector at 0x02
// RULE8 - voltage monitor vector sits at word 0x04 on every variant
// RULE9 - realtime counter overflow or compare vector sits at word 0x06
// RULE10 - scratch register bank decodes at 0x001C on every variant
// RULE11 - memory check unit decodes from 0x0120 on every variant
// RULE12 - serial ports 0, 1, 2 decode at 0x0800, 0x0820, 0x0840 always
// RULE13 - serial port 3 decodes at 0x0860, only in 40 and 48 pin variants
// RULE14 - timer A decodes at 0x0A00 on every variant
// RULE15 - timer B 0, 1, 2 decode at 0x0A80, 0x0A90, 0x0AA0 always
// RULE16 - timer B 3 decodes at 0x0AB0, only in 40 and 48 pin variants
// RULE17 - nonvolatile controller decodes at 0x1000 on every variant
// RULE18 - unmapped or absent module addresses select nothing and read zero
package pdv_pkg;
  localparam int PDV_AW = 16;
  localparam int PDV_DW = 8;
  localparam int PDV_NSEL = 12;
  localparam int PDV_NSRC = 4;
  localparam int PDV_NVEC = 4;
  localparam int PDV_VW = 8;

  typedef enum logic [1:0]
  {
    PDV_PIN28 = 2'h0,
    PDV_PIN32 = 2'h1,
    PDV_PIN40 = 2'h2,
    PDV_PIN48 = 2'h3
  } pdv_variant_t;

  // select index order: scratch, memcheck, serial 0..3, timer a, timer b 0..3, nvm
  localparam int PDV_SEL_SCRATCH = 0;
  localparam int PDV_SEL_MEMCHECK = 1;
  localparam int PDV_SEL_SERIAL3 = 5;
  localparam int PDV_SEL_TIMERB3 = 10;
  localparam int PDV_SEL_NVM = 11;

  localparam logic [PDV_NSEL-1:0][PDV_AW-1:0] PDV_BASE = {
    16'h1000, 16'h0ab0, 16'h0aa0, 16'h0a90, 16'h0a80, 16'h0a00,
    16'h0860, 16'h0840, 16'h0820, 16'h0800, 16'h0120, 16'h001c};
  // span of each window minus one
  localparam logic [PDV_NSEL-1:0][PDV_AW-1:0] PDV_SPAN = {
    16'h00ff, 16'h000f, 16'h000f, 16'h000f, 16'h000f, 16'h007f,
    16'h001f, 16'h001f, 16'h001f, 16'h001f, 16'h001f, 16'h0003};
  // windows present only on the two large variants
  // serial port 3 (bit 5) and timer b 3 (bit 10)
  localparam logic [PDV_NSEL-1:0] PDV_LARGE_ONLY = 12'h420;

  // sources: memcheck nmi, voltage monitor, rtc overflow, rtc compare
  localparam int PDV_SRC_NMI = 0;
  localparam logic [PDV_NSRC-1:0][1:0] PDV_SRC_VEC = {2'h3, 2'h3, 2'h2, 2'h1};
  localparam logic [PDV_NSRC-1:0] PDV_SRC_NONMASK = 4'h1;
  localparam logic [PDV_NVEC-1:0][PDV_VW-1:0] PDV_VEC_ADDR = {
    8'h06, 8'h04, 8'h02, 8'h00};
  localparam logic [PDV_VW-1:0] PDV_RESET_VEC = 8'h00;
endpackage : pdv_pkg

/* logic/pdv_decode_vectors.sv */
// peripheral address decode and generic interrupt request / vector logic
// assumes core access strobes and peripheral events arrive on mclk_in
`timescale 1ns/100ps
module pdv_decode_vectors
  import pdv_pkg::*;
#(
  parameter pdv_variant_t VARIANT = PDV_PIN48,
  parameter int NSRC = PDV_NSRC
)
(
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // core access
  input wire logic [PDV_AW-1:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  output logic [PDV_NSEL-1:0] sel_out,
  output logic [PDV_DW-1:0] rdata_out,
  // read data of the selected peripheral
  input wire logic [PDV_DW-1:0] periph_rdata_in,
  // interrupt sources
  input wire logic [NSRC-1:0] flag_set_in,
  input wire logic [NSRC-1:0] flag_clr_in,
  input wire logic [NSRC-1:0] irq_en_in,
  input wire logic global_en_in,
  // flag and request state
  output logic [NSRC-1:0] flag_out,
  output logic [NSRC-1:0] src_req_out,
  output logic [PDV_NVEC-1:0] vec_req_out,
  output logic vec_valid_out,
  output logic [PDV_VW-1:0] vec_addr_out
);
  logic [PDV_NSEL-1:0] sel_ff;
  logic [PDV_DW-1:0] rdata_ff;
  logic rd_q_ff;
  logic [NSRC-1:0] flag_ff;
  logic [NSRC-1:0] req_ff;
  logic [PDV_NVEC-1:0] vec_ff;
  logic vec_valid_ff;
  logic [PDV_VW-1:0] vec_addr_ff;

  // decode
  wire large_pkg = (VARIANT == PDV_PIN40) || (VARIANT == PDV_PIN48);
  wire access = rd_in | wr_in;
  wire [PDV_NSEL-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < PDV_NSEL; g++)
    begin : g_win
      // absent modules never match, so their window reads as unmapped
      assign hit[g] = ((addr_in & ~PDV_SPAN[g]) == PDV_BASE[g])
                      && (large_pkg || !PDV_LARGE_ONLY[g]); // [RULE10] [RULE11] [RULE13] [RULE16]
    end
  endgenerate
  wire [PDV_NSEL-1:0] nxt_sel = access ? hit : '0; // [RULE12] [RULE14] [RULE15] [RULE17]
  // unselected read returns zero rather than stale bus data
  wire [PDV_DW-1:0] nxt_rdata = (rd_q_ff && (|sel_ff)) ? periph_rdata_in : '0; // [RULE18]

  // interrupt flags: set wins over clear so a coincident event is kept
  wire [NSRC-1:0] nxt_flag = (flag_ff & ~flag_clr_in) | flag_set_in; // [RULE2] [RULE5]
  wire [NSRC-1:0] gate = PDV_SRC_NONMASK | {NSRC{global_en_in}}; // [RULE6]
  wire [NSRC-1:0] nxt_req = flag_ff & irq_en_in & gate; // [RULE3] [RULE4]
  logic [PDV_NVEC-1:0] nxt_vec;
  logic [PDV_VW-1:0] nxt_vec_addr;
  always_comb
  begin
    nxt_vec = '0;
    for (int s = 0; s < NSRC; s++)
    begin
      // several sources of one peripheral merge onto its single vector
      nxt_vec[PDV_SRC_VEC[s]] = nxt_vec[PDV_SRC_VEC[s]] | req_ff[s]; // [RULE1]
    end
    nxt_vec_addr = PDV_RESET_VEC;
    // lowest vector number wins, scanned from the top down
    for (int v = PDV_NVEC - 1; v > 0; v--)
    begin
      if (vec_ff[v])
      begin
        nxt_vec_addr = PDV_VEC_ADDR[v]; // [RULE7] [RULE8] [RULE9]
      end
    end
  end
  wire nxt_vec_valid = |vec_ff[PDV_NVEC-1:1];

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      sel_ff <= '0;
      rd_q_ff <= 1'b0;
      rdata_ff <= '0;
      flag_ff <= '0;
      req_ff <= '0;
      vec_ff <= '0;
      vec_valid_ff <= 1'b0;
      vec_addr_ff <= PDV_RESET_VEC;
    end
    else if (clk_en_in)
    begin
      sel_ff <= nxt_sel;
      rd_q_ff <= rd_in;
      rdata_ff <= nxt_rdata;
      flag_ff <= nxt_flag;
      req_ff <= nxt_req;
      vec_ff <= nxt_vec;
      vec_valid_ff <= nxt_vec_valid;
      vec_addr_ff <= nxt_vec_addr;
    end
  end

  assign sel_out = sel_ff;
  assign rdata_out = rdata_ff;
  assign flag_out = flag_ff;
  assign src_req_out = req_ff;
  assign vec_req_out = vec_ff;
  assign vec_valid_out = vec_valid_ff;
  assign vec_addr_out = vec_addr_ff;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // scratch bank, address 0x001d, must be selected on any variant
  scratch_sel_a: assert property ( // [RULE10]
    (clk_en_in && rd_in && addr_in == 16'h001d) |=> sel_ff[PDV_SEL_SCRATCH])
    else $error("scratch bank not selected");

  memcheck_sel_a: assert property ( // [RULE11]
    (clk_en_in && wr_in && addr_in == 16'h0120) |=> sel_ff == 12'h002)
    else $error("memory check unit not selected alone");

  serial3_var_a: assert property ( // [RULE13]
    (clk_en_in && access && addr_in == 16'h0860)
    |=> sel_ff[PDV_SEL_SERIAL3] == large_pkg)
    else $error("serial port 3 presence wrong");

  timerb3_var_a: assert property ( // [RULE16]
    (clk_en_in && access && addr_in == 16'h0ab5)
    |=> sel_ff[PDV_SEL_TIMERB3] == large_pkg)
    else $error("timer b 3 presence wrong");

  unmapped_zero_a: assert property ( // [RULE18]
    (clk_en_in && rd_in && addr_in == 16'h0f00) ##1 clk_en_in |=> rdata_ff == '0)
    else $error("unmapped read not zero");

  flag_set_a: assert property ( // [RULE2]
    (clk_en_in && flag_set_in[1]) |=> flag_ff[1])
    else $error("flag not set by event");

  sequence flag_held_s;
    flag_ff[2] && irq_en_in[2] && global_en_in && clk_en_in;
  endsequence
  req_level_a: assert property ( // [RULE4] [RULE5]
    flag_held_s ##1 (flag_held_s and !flag_clr_in[2]) |=> req_ff[2])
    else $error("request dropped while flag held");

  global_gate_a: assert property ( // [RULE6]
    (clk_en_in && !global_en_in) |=> req_ff[3:1] == '0)
    else $error("maskable request without global enable");

  nmi_ungated_a: assert property ( // [RULE6]
    (clk_en_in && flag_ff[PDV_SRC_NMI] && irq_en_in[PDV_SRC_NMI]) |=> req_ff[PDV_SRC_NMI])
    else $error("nonmaskable request blocked");

  vec_addr_a: assert property ( // [RULE7] [RULE8] [RULE9]
    (clk_en_in && vec_ff[1]) |=> vec_addr_ff == 8'h02)
    else $error("vector 1 address wrong");

  vec_rtc_a: assert property ( // [RULE1] [RULE9]
    (clk_en_in && (req_ff[2] || req_ff[3])) |=> vec_ff[3])
    else $error("rtc sources not merged onto vector 3");

  serial0_sel_a: assert property ( // [RULE12]
    (clk_en_in && rd_in && addr_in == 16'h0800) |=> sel_ff == 12'h004)
    else $error("serial port 0 not selected alone");

  serial1_sel_a: assert property ( // [RULE12]
    (clk_en_in && rd_in && addr_in == 16'h083f) |=> sel_ff == 12'h008)
    else $error("serial port 1 not selected alone");

  serial2_sel_a: assert property ( // [RULE12]
    (clk_en_in && wr_in && addr_in == 16'h0840) |=> sel_ff == 12'h010)
    else $error("serial port 2 not selected alone");

  timera_sel_a: assert property ( // [RULE14]
    (clk_en_in && access && addr_in == 16'h0a7f) |=> sel_ff == 12'h040)
    else $error("timer a not selected alone");

  timerb0_sel_a: assert property ( // [RULE15]
    (clk_en_in && access && addr_in == 16'h0a80) |=> sel_ff == 12'h080)
    else $error("timer b 0 not selected alone");

  timerb1_sel_a: assert property ( // [RULE15]
    (clk_en_in && access && addr_in == 16'h0a9f) |=> sel_ff == 12'h100)
    else $error("timer b 1 not selected alone");

  timerb2_sel_a: assert property ( // [RULE15]
    (clk_en_in && access && addr_in == 16'h0aa0) |=> sel_ff == 12'h200)
    else $error("timer b 2 not selected alone");

  nvm_sel_a: assert property ( // [RULE17]
    (clk_en_in && access && addr_in == 16'h1000) |=> sel_ff == 12'h800)
    else $error("nonvolatile controller not selected alone");

  gap_none_a: assert property ( // [RULE18]
    (clk_en_in && access && addr_in == 16'h0880) |=> sel_ff == '0)
    else $error("gap address selected a module");

  idle_none_a: assert property ( // [RULE18]
    (clk_en_in && !access) |=> sel_ff == '0)
    else $error("select without access");

  sel_onehot_a: assert property ( // [RULE18]
    $onehot0(sel_ff))
    else $error("more than one module selected");

  rdata_pass_a: assert property ( // [RULE18]
    (clk_en_in && rd_q_ff && (|sel_ff)) |=> rdata_ff == $past(periph_rdata_in))
    else $error("selected read data not passed");

  noread_zero_a: assert property ( // [RULE18]
    (clk_en_in && !rd_q_ff) |=> rdata_ff == '0)
    else $error("read data without read");

  flag_clear_a: assert property ( // [RULE5]
    (clk_en_in && flag_clr_in[1] && !flag_set_in[1]) |=> !flag_ff[1])
    else $error("flag not cleared");

  set_wins_a: assert property ( // [RULE2]
    (clk_en_in && flag_set_in[3] && flag_clr_in[3]) |=> flag_ff[3])
    else $error("coincident clear beat the event");

  flag_hold_a: assert property ( // [RULE5]
    (clk_en_in && flag_ff[0] && !flag_clr_in[0]) |=> flag_ff[0])
    else $error("flag dropped without clear");

  enable_gate_a: assert property ( // [RULE3]
    (clk_en_in && !irq_en_in[1]) |=> !req_ff[1])
    else $error("request from disabled source");

  noflag_noreq_a: assert property ( // [RULE4]
    (clk_en_in && !flag_ff[3]) |=> !req_ff[3])
    else $error("request without flag");

  vec_none_a: assert property ( // [RULE7]
    (clk_en_in && vec_ff[3:1] == 3'h0) |=> (!vec_valid_ff && vec_addr_ff == 8'h00))
    else $error("vector shown with no request");

  vec2_addr_a: assert property ( // [RULE8]
    (clk_en_in && vec_ff[2] && !vec_ff[1]) |=> vec_addr_ff == 8'h04)
    else $error("vector 2 address wrong");

  vec3_addr_a: assert property ( // [RULE9]
    (clk_en_in && vec_ff[3] && vec_ff[2:1] == 2'h0) |=> vec_addr_ff == 8'h06)
    else $error("vector 3 address wrong");

  vec_valid_a: assert property ( // [RULE7]
    (clk_en_in && (|vec_ff[3:1])) |=> vec_valid_ff)
    else $error("vector request not flagged valid");

  vec_reset_free_a: assert property ( // [RULE7]
    vec_ff[0] == 1'b0)
    else $error("reset vector requested by a source");

  volt_vec_a: assert property ( // [RULE8]
    (clk_en_in && req_ff[1]) |=> vec_ff[2])
    else $error("voltage monitor not on vector 2");

  nmi_vec_a: assert property ( // [RULE1]
    (clk_en_in && req_ff[0]) |=> vec_ff[1])
    else $error("memory check source not on vector 1");

  // clock enable low must freeze the flag, request and select registers
  freeze_hold_a: assert property (
    !clk_en_in |=> ($stable(flag_ff) && $stable(req_ff) && $stable(sel_ff)))
    else $error("state moved while clock enable low");
endmodule : pdv_decode_vectors

/* sim/pdv_periph_model.sv */
// peripheral side model: read data for the selected window
// assumes sel_in is registered on mclk_in
`timescale 1ns/100ps
module pdv_periph_model
  import pdv_pkg::*;
(
  // clock and select
  input wire logic mclk_in,
  input wire logic [PDV_NSEL-1:0] sel_in,
  // read data
  output logic [PDV_DW-1:0] rdata_out
);
  logic [PDV_DW-1:0] idle_ff = 8'h01;
  // idle bus churns and is never zero, so a stale read cannot pass
  always_ff @(posedge mclk_in)
  begin
    idle_ff <= idle_ff + 8'h02;
  end
  always_comb
  begin
    rdata_out = idle_ff;
    for (int i = 0; i < PDV_NSEL; i++)
      if (sel_in[i])
        rdata_out = 8'h80 | 8'(i);
  end
endmodule : pdv_periph_model

/* sim/tb_pdv_decode_vectors.sv */
// self-checking bench for the decode and vector block
// assumes 10 MHz clock; small and large variants run side by side
`timescale 1ns/100ps
module tb_pdv_decode_vectors;
  import pdv_pkg::*;
  logic mclk_in = 0, resetn_in = 0, clk_en_in = 1, rd_in = 0, wr_in = 0, global_en_in = 0;
  logic [PDV_AW-1:0] addr_in = 16'h0000;
  logic [3:0] flag_set_in = 4'h0, flag_clr_in = 4'h0, irq_en_in = 4'h0;
  logic [PDV_NSEL-1:0] sel_out, sel_big;
  logic [PDV_DW-1:0] rdata_out, prd;
  logic [3:0] flag_out, src_req_out, vec_req_out;
  logic vec_valid_out;
  logic [PDV_VW-1:0] vec_addr_out;
  int fail_count = 0, checked = 0, cyc = 0;
  logic [15:0] adr [14] = '{16'h001c, 16'h001f, 16'h0120, 16'h0800, 16'h0820, 16'h0840,
    16'h0860, 16'h0a00, 16'h0a80, 16'h0a90, 16'h0aa0, 16'h0ab0, 16'h0020, 16'h0f00};
  int sm [14] = '{0, 0, 1, 2, 3, 4, -1, 6, 7, 8, 9, -1, -1, -1};
  int lg [14] = '{0, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, -1, -1};
  always #50 mclk_in = ~mclk_in;
  pdv_decode_vectors #(.VARIANT(PDV_PIN28)) dut (.mclk_in, .resetn_in, .clk_en_in, .addr_in,
    .rd_in, .wr_in, .sel_out, .rdata_out, .periph_rdata_in(prd), .flag_set_in, .flag_clr_in,
    .irq_en_in, .global_en_in, .flag_out, .src_req_out, .vec_req_out, .vec_valid_out,
    .vec_addr_out);
  pdv_decode_vectors #(.VARIANT(PDV_PIN48)) dut_large (.mclk_in, .resetn_in, .clk_en_in,
    .addr_in, .rd_in, .wr_in, .sel_out(sel_big), .rdata_out(), .periph_rdata_in(prd),
    .flag_set_in, .flag_clr_in, .irq_en_in, .global_en_in, .flag_out(), .src_req_out(),
    .vec_req_out(), .vec_valid_out(), .vec_addr_out());
  pdv_periph_model model (.mclk_in, .sel_in(sel_out), .rdata_out(prd));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // one access; index -1 means nothing may be selected
  task automatic access(input logic [15:0] a, input int s, input int l, input logic wr);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= ~wr;
    wr_in <= wr;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    wr_in <= 1'b0;
    #1;
    check("sel", sel_out, (s < 0) ? 12'h000 : 12'h001 << s);
    check("sel_large", sel_big, (l < 0) ? 12'h000 : 12'h001 << l);
    @(posedge mclk_in);
    #1;
    if (!wr)
      check("rdata", rdata_out, (s < 0) ? 8'h00 : 8'h80 | 8'(s));
  endtask : access
  task automatic nvm_read();
    @(posedge mclk_in);
    addr_in <= 16'h1000;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    check("nvm_sel", sel_out, 12'h800);
    check("nvm_sel_large", sel_big, 12'h800);
  endtask : nvm_read
  // an event while the clock enable is low must be lost
  task automatic freeze();
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    flag_set_in <= 4'h2;
    repeat (2) @(posedge mclk_in);
    clk_en_in <= 1'b1;
    flag_set_in <= 4'h0;
    #1;
    check("frozen", flag_out, 4'h0);
  endtask : freeze
  // set a source, mask it two ways, then clear it
  task automatic irq_walk(input int s, input logic [7:0] va, input int v);
    @(posedge mclk_in);
    flag_set_in <= 4'h1 << s;
    @(posedge mclk_in);
    flag_set_in <= 4'h0;
    repeat (4) @(posedge mclk_in);
    #1;
    check("flag", flag_out, 4'h1 << s);
    check("src_req", src_req_out, 4'h1 << s);
    check("vec_req", vec_req_out, 4'h1 << v);
    check("vec", {vec_valid_out, vec_addr_out}, {1'b1, va});
    @(posedge mclk_in);
    global_en_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    check("masked", src_req_out[s], (s == 0) ? 1'b1 : 1'b0);
    @(posedge mclk_in);
    global_en_in <= 1'b1;
    irq_en_in <= ~(4'h1 << s);
    repeat (3) @(posedge mclk_in);
    #1;
    check("disabled", {src_req_out[s], flag_out[s]}, 2'h1);
    @(posedge mclk_in);
    irq_en_in <= 4'hf;
    repeat (3) @(posedge mclk_in);
    #1;
    check("held", src_req_out[s], 1'b1);
    @(posedge mclk_in);
    flag_clr_in <= 4'h1 << s;
    @(posedge mclk_in);
    flag_clr_in <= 4'h0;
    repeat (5) @(posedge mclk_in);
    #1;
    check("cleared", {flag_out, src_req_out, vec_req_out}, 16'h0000);
    check("cleared_vec", {vec_valid_out, vec_addr_out}, 16'h0000);
  endtask : irq_walk
  // ceiling well above the roughly 170 cycles the sequence needs
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk_in);
    resetn_in <= 1'b1;
    global_en_in <= 1'b1;
    irq_en_in <= 4'hf;
    #1;
    check("reset_vec", {vec_valid_out, vec_addr_out}, 9'h000);
    foreach (adr[i])
      access(adr[i], sm[i], lg[i], i % 4 == 1);
    nvm_read();
    freeze();
    irq_walk(0, 8'h02, 1);
    irq_walk(1, 8'h04, 2);
    irq_walk(2, 8'h06, 3);
    irq_walk(3, 8'h06, 3);
    end_of_test();
  end
endmodule : tb_pdv_decode_vectors
